// ==== bench/core_chk.sv ====
// port assertions for the decode and execution core
`timescale 1ns/10ps
module core_chk (
   // watched ports
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [14:0] prog_addr,
   input wire logic [7:0]  data_addr,
   input wire logic        data_wr,
   input wire logic [7:0]  data_wdata,
   input wire logic        irq_req,
   input wire logic        irq_ack,
   input wire logic        global_irq_en
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_ack_cause: assert property (
      irq_ack |-> global_irq_en && $past(irq_req)) else $error("ack without enable");
   chk_ack_single: assert property (
      irq_ack |=> !irq_ack [*6]) else $error("ack not single");
   chk_entry_target: assert property (
      irq_ack |-> ##7 prog_addr == 15'h00ff) else $error("entry target wrong");
   chk_entry_gie: assert property (
      irq_ack |-> ##7 !global_irq_en) else $error("enable not cleared");
   chk_entry_push: assert property (
      irq_ack |=> data_wr ##1 data_wr) else $error("entry push missing");
   chk_upper_byte: assert property (
      data_wr && $past(data_wr) |-> !data_wdata[7] && data_addr == $past(data_addr) - 8'h01)
      else $error("upper pc byte misplaced");
   chk_burst_max: assert property (
      data_wr ##1 data_wr |=> !data_wr) else $error("write burst too long");
   chk_gie_fall: assert property (
      $fell(global_irq_en) |-> prog_addr == 15'h00ff) else $error("enable fell off entry");
   cover property (irq_ack);
   cover property (data_wr ##1 data_wr);
   cover property ($rose(global_irq_en));
endmodule
bind mcu_instruction_decode_exec core_chk u_chk (
   .ref_clk       (ref_clk),
   .rst           (rst),
   .prog_addr     (prog_addr),
   .data_addr     (data_addr),
   .data_wr       (data_wr),
   .data_wdata    (data_wdata),
   .irq_req       (irq_req),
   .irq_ack       (irq_ack),
   .global_irq_en (global_irq_en)
);

// ==== bench/core_mem.sv ====
// program and data memory model facing the core
`timescale 1ns/10ps
module core_mem (
   // core side
   input  wire logic        ref_clk,
   input  wire logic [14:0] prog_addr,
   output logic      [7:0]  prog_data,
   input  wire logic [7:0]  data_addr,
   output logic      [7:0]  data_rdata,
   input  wire logic        data_wr,
   input  wire logic [7:0]  data_wdata
);
   logic [7:0] prog [32768];
   logic [7:0] data [256];
   initial
   begin
      foreach (prog[i]) prog[i] = 8'h04;
      foreach (data[i]) data[i] = 8'h00;
   end
   // reads answer in the same cycle, writes land at the edge
   assign prog_data  = prog[prog_addr];
   assign data_rdata = data[data_addr];
   always @(posedge ref_clk)
      if (data_wr) data[data_addr] <= data_wdata;
endmodule

// ==== bench/mcu_instruction_decode_exec_tb.sv ====
// self-checking bench for the decode and execution core
`timescale 1ns/10ps
module mcu_instruction_decode_exec_tb;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        irq_req = 1'b0;
   logic [14:0] irq_vec_addr = 15'h0000;
   logic [14:0] prog_addr;
   logic [7:0]  prog_data, data_addr, data_rdata, data_wdata, acc, k, j, v;
   logic        data_wr, irq_ack, global_irq_en;
   int          fails = 0, tests_run = 0, cyc = 0;
   mcu_instruction_decode_exec DUT (.ref_clk(ref_clk), .rst(rst), .prog_addr(prog_addr),
      .prog_data(prog_data), .data_addr(data_addr), .data_rdata(data_rdata),
      .data_wr(data_wr), .data_wdata(data_wdata), .irq_req(irq_req),
      .irq_vec_addr(irq_vec_addr), .irq_ack(irq_ack), .global_irq_en(global_irq_en),
      .acc(acc));
   core_mem mem (.ref_clk(ref_clk), .prog_addr(prog_addr), .prog_data(prog_data),
      .data_addr(data_addr), .data_rdata(data_rdata), .data_wr(data_wr),
      .data_wdata(data_wdata));
   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 500)
      begin
         fails++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("tests_run=%0d fails=%0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [14:0] exp, input logic [14:0] got);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic run(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask
   task automatic restart();
      rst = 1'b1;
      @(posedge ref_clk);
      #10 rst = 1'b0;
   endtask
   task automatic code(input logic [14:0] a, input logic [7:0] b[$]);
      foreach (b[i]) mem.prog[a + 15'(i)] = b[i];
   endtask
   // relative jump lands at its own address plus field minus 31
   function automatic logic [14:0] jp_dest(input logic [14:0] pc, input logic [7:0] op);
      return pc + {9'h000, op[5:0]} - 15'h001f;
   endfunction
   initial
   begin
      void'($urandom(32'hae87));
      // vector pair kept clear of every code address used below
      irq_vec_addr = {3'b011, 12'($urandom)};
      k = 8'($urandom);
      j = 8'($urandom);
      code(15'h0000, '{8'hd8, k, 8'hee, 8'hd8, j, 8'hef});
      repeat (6) @(posedge ref_clk);
      #10 rst = 1'b0;
      run(2);
      cmp("acc imm", k, acc);
      run(3);
      cmp("stack byte", k, mem.data[8'h6f]);
      run(2);
      cmp("acc sum", 8'(k + j), acc);
      run(3);
      cmp("acc pop", k, acc);
      v = {2'b01, 6'($urandom)};
      code(15'h0000, '{8'hf2, 8'h5f, 8'hf0});
      code(15'h5ff0, '{8'ha3, k});
      code({7'h53, k}, '{v});
      restart();
      run(4);
      cmp("pc long", 15'h5ff0, prog_addr);
      run(3);
      cmp("pc seg", {7'h53, k}, prog_addr);
      run(v == 8'h60 ? 1 : 3);
      cmp("pc rel", jp_dest({7'h53, k}, v), prog_addr);
      k = 8'h80 | 8'($urandom);
      v = 8'($urandom);
      code(15'h0000, '{8'hd8, k, 8'hf1, ~k, 8'hd8, 8'h11, 8'he8});
      mem.prog[{7'h00, k}] = v;
      restart();
      run(6);
      cmp("pc skip", 15'h0006, prog_addr);
      cmp("acc kept", k, acc);
      run(3);
      cmp("acc table", v, acc);
      mem.data[8'hf0] = 8'h01;
      code(15'h0000, '{8'hc0, 8'hd8, 8'h22, 8'hd8, j});
      restart();
      run(3);
      cmp("reg dec", 8'h00, mem.data[8'hf0]);
      run(4);
      cmp("acc after skip", j, acc);
      code(15'h0000, '{8'hb3, 8'h40});
      code(15'h0340, '{8'hea});
      code(irq_vec_addr, '{8'h01, j});
      code({7'h01, j}, '{8'heb});
      restart();
      run(5);
      cmp("pc call", 15'h0340, prog_addr);
      run(5);
      cmp("pc vector", {7'h01, j}, prog_addr);
      run(5);
      cmp("pc return", 15'h0002, prog_addr);
      code(15'h0000, '{8'h00, 8'h04});
      code(15'h00ff, '{8'hed});
      restart();
      run(7);
      cmp("pc trap", 15'h00ff, prog_addr);
      cmp("stack low", 8'h01, mem.data[8'h6f]);
      cmp("stack high", 8'h00, mem.data[8'h6e]);
      run(5);
      cmp("pc back", 15'h0001, prog_addr);
      cmp("irq enable", 1'b1, global_irq_en);
      irq_req = 1'b1;
      for (int i = 0; i < 10 && irq_ack !== 1'b1; i++) run(1);
      cmp("irq ack", 1'b1, irq_ack);
      irq_req = 1'b0;
      run(7);
      cmp("pc irq", 15'h00ff, prog_addr);
      cmp("irq masked", 1'b0, global_irq_en);
      run(1);
      wrap_up();
   end
endmodule

// ==== inc/core_params.svh ====
// constants for the instruction decode and execution core
`ifndef CORE_PARAMS_SVH
`define CORE_PARAMS_SVH

// fixed addresses and reset values
`define SWI_VECTOR    15'h00ff
`define REG_PAGE      4'hf
`define SP_RESET      8'h6f
`define PC_RESET      15'h0000
`define JP_BIAS       15'h001f

// single opcodes
`define OP_SWI        8'h00
`define OP_LDB_IMM    8'h03
`define OP_NOP        8'h60
`define OP_JP_FIRST   8'h40
`define OP_JP_LAST    8'h7f

// field positions
`define PL_MSB        7
`define PU_LSB        8
`define PC_MSB        14
`define SEG_LSB       12

// execution lengths in instruction cycles
`define CYC_ONE       3'd1
`define CYC_TWO       3'd2
`define CYC_THREE     3'd3
`define CYC_FOUR      3'd4
`define CYC_FIVE      3'd5
`define CYC_SEVEN     3'd7

`endif

// ==== inc/core_pkg.sv ====
// types shared by the instruction decode and execution core
package core_pkg;

   typedef enum logic [4:0]
   {
      no_op,
      software_irq_entry,
      load_reg_imm,
      short_relative_jump,
      load_b_short,
      b_nibble_compare_skip,
      absolute_segment_jump,
      absolute_segment_call,
      decrement_skip_zero,
      alu_indirect,
      alu_immediate,
      alu_direct,
      load_acc_from_rom_table,
      jump_via_rom_table,
      vector_to_service,
      subroutine_exit,
      exit_and_skip,
      interrupt_exit,
      push_acc,
      pop_acc,
      decimal_adjust,
      mask_test_skip,
      long_absolute_jump,
      long_absolute_call,
      mem_transfer
   } op_class_e;

   typedef logic [3:0] alu_fn_t;

endpackage

// ==== rtl/alu_unit.sv ====
// accumulator arithmetic, logic, compare and decimal adjust
`timescale 1ns/10ps
`include "core_params.svh"

module alu_unit
   import core_pkg::*;
(
   // operands
   input  wire logic [7:0] acc_in,
   input  wire logic [7:0] operand,
   input  wire logic       carry_in,
   input  wire logic       half_carry_in,
   input  wire alu_fn_t    fn,
   // results
   output logic      [7:0] result,
   output logic            carry_out,
   output logic            half_carry_out,
   output logic            cond_true
);

   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] addend;
   logic       cin;

   // subtract with carry adds the complement, carry meaning no borrow
   assign addend  = (fn == 4'h2) ? ~operand : operand;
   assign cin     = (fn == 4'h1 || fn == 4'h2) ? carry_in : 1'b0;
   assign sum     = {1'b0, acc_in} + {1'b0, addend} + {8'h00, cin};
   assign low_sum = {1'b0, acc_in[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};

   always_comb
   begin
      result         = acc_in;
      carry_out      = carry_in;
      half_carry_out = half_carry_in;
      cond_true      = 1'b0;
      unique case (fn)
         4'h0:
         begin
            result = sum[7:0];
         end
         4'h1, 4'h2:
         begin
            result         = sum[7:0];
            carry_out      = sum[8];
            half_carry_out = low_sum[4];
         end
         4'h3: result = acc_in & operand;
         4'h4: result = acc_in | operand;
         4'h5: result = acc_in ^ operand;
         4'h6: cond_true = (acc_in == operand);
         4'h7: cond_true = (acc_in > operand);
         // bcd correction: a clear carry or half carry takes six off that digit
         default: result = acc_in - {(carry_in ? 4'h0 : 4'h6), (half_carry_in ? 4'h0 : 4'h6)};
      endcase
   end

endmodule

// ==== rtl/mcu_instruction_decode_exec.sv ====
// instruction decode and execution sequencer of the 8-bit accumulator core
`timescale 1ns/10ps
`include "core_params.svh"

// Behaviour
// - immediate operand comes from the instruction's 8-bit field
// - load B short form carries a 4-bit operand in one byte
// - table load reads program memory at upper pc and accumulator, three cycles
// - relative jump adds -31..+32 over all 15 pc bits; +1 is no-op
// - segment jump and call replace only low twelve pc bits
// - long jump and call load all fifteen pc bits
// - indirect jump loads low pc byte from program memory at upper pc, accumulator
// - vector instruction loads two adjacent vector bytes into pc, five cycles
// - mask test ANDs accumulator with immediate, skips on zero, two cycles
// - decrement register byte, write back, skip when zero, three cycles
// - B nibble compare executes next only when low nibble of B differs
// - skipped instruction costs one cycle per opcode byte
// - push writes then decrements; pop increments then reads; three cycles
// - software interrupt pushes pc, drops stack by two, jumps to 0FF
// - return raises stack by two and reloads pc, five cycles
// - interrupt return restores pc like return and sets interrupt enable
// - every instruction takes its own byte and cycle count
// - load and exchange take 1, 3, 2 or 3 cycles by pointer mode
// - register operands lie in F0..FF including B, X and stack pointer
// - pc is fifteen bits: upper seven and low byte moved separately
// - decimal adjust corrects accumulator after add or subtract with carry
module mcu_instruction_decode_exec
   import core_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // program memory, read data follows the address in the same cycle
   output logic      [14:0] prog_addr,
   input  wire logic [7:0]  prog_data,
   // data memory, read data follows the address in the same cycle
   output logic      [7:0]  data_addr,
   input  wire logic [7:0]  data_rdata,
   output logic             data_wr,
   output logic      [7:0]  data_wdata,
   // interrupts
   input  wire logic        irq_req,
   input  wire logic [14:0] irq_vec_addr,
   output logic             irq_ack,
   output logic             global_irq_en,
   // visible core state
   output logic      [7:0]  acc
);

   function automatic op_class_e decode_op(input logic [7:0] o);
      op_class_e c;
      c = no_op;
      if (o == `OP_SWI)
         c = software_irq_entry;
      else if (o <= `OP_LDB_IMM)
         c = load_reg_imm;
      else if (o >= `OP_JP_FIRST && o <= `OP_JP_LAST && o != `OP_NOP)
         c = short_relative_jump;
      else if (o[7])
      begin
         unique case (o[6:4])
            3'h0: c = load_b_short;
            3'h1: c = b_nibble_compare_skip;
            3'h2: c = absolute_segment_jump;
            3'h3: c = absolute_segment_call;
            3'h4: c = decrement_skip_zero;
            3'h5: c = o[3] ? alu_immediate : alu_indirect;
            3'h6:
            begin
               unique case (o[3:0])
                  4'h8: c = load_acc_from_rom_table;
                  4'h9: c = jump_via_rom_table;
                  4'ha: c = vector_to_service;
                  4'hb: c = subroutine_exit;
                  4'hc: c = exit_and_skip;
                  4'hd: c = interrupt_exit;
                  4'he: c = push_acc;
                  4'hf: c = pop_acc;
                  default: c = alu_direct;
               endcase
            end
            3'h7:
            begin
               unique case (o[3:0])
                  4'h0: c = decimal_adjust;
                  4'h1: c = mask_test_skip;
                  4'h2: c = long_absolute_jump;
                  4'h3: c = long_absolute_call;
                  default: c = (o[3:0] >= 4'h4) ? mem_transfer : no_op;
               endcase
            end
         endcase
      end
      return c;
   endfunction

   function automatic logic [1:0] op_bytes(input op_class_e c);
      if (c == alu_direct || c == long_absolute_jump || c == long_absolute_call)
         return 2'd3;
      if (c == alu_immediate || c == load_reg_imm || c == absolute_segment_jump
          || c == absolute_segment_call || c == mask_test_skip)
         return 2'd2;
      return 2'd1;
   endfunction

   function automatic logic [2:0] op_cycles(input op_class_e c, input logic [7:0] o);
      logic [2:0] n;
      n = `CYC_ONE;
      if (c == alu_immediate || c == load_reg_imm || c == mask_test_skip)
         n = `CYC_TWO;
      if (c == load_acc_from_rom_table || c == short_relative_jump || c == absolute_segment_jump
          || c == jump_via_rom_table || c == push_acc || c == pop_acc
          || c == decrement_skip_zero)
         n = `CYC_THREE;
      if (c == alu_direct || c == long_absolute_jump)
         n = `CYC_FOUR;
      if (c == absolute_segment_call || c == long_absolute_call || c == vector_to_service
          || c == subroutine_exit || c == exit_and_skip || c == interrupt_exit)
         n = `CYC_FIVE;
      if (c == software_irq_entry)
         n = `CYC_SEVEN;
      if (c == mem_transfer)
         n = (o[3] ? o[2] : o[1]) ? `CYC_THREE : (o[3] ? `CYC_TWO : `CYC_ONE);
      return n;
   endfunction

   logic [14:0] pc;
   logic [7:0]  b;
   logic [7:0]  x;
   logic [7:0]  sp;
   logic        carry;
   logic        half_carry;
   logic        skip;
   logic        hw_entry;
   logic [2:0]  step;
   logic [7:0]  op;
   logic [7:0]  t1;
   logic [7:0]  t2;

   logic [14:0] next_pc;
   logic [14:0] next_prog_addr;
   logic [7:0]  next_b;
   logic [7:0]  next_x;
   logic [7:0]  next_sp;
   logic [7:0]  next_acc;
   logic        next_carry;
   logic        next_half_carry;
   logic        next_gie;
   logic        next_skip;
   logic        next_hw_entry;
   logic        next_irq_ack;
   logic [2:0]  next_step;
   logic [7:0]  next_t1;
   logic [7:0]  next_t2;
   logic [7:0]  next_data_addr;
   logic        next_data_wr;
   logic [7:0]  next_data_wdata;
   logic [14:0] tgt;
   logic        skip_set;

   // decode of the current opcode: byte 0 is live on the bus in the first cycle
   wire logic [7:0]  opc      = (step == 3'd0) ? (hw_entry ? `OP_SWI : prog_data) : op;
   wire op_class_e   cls      = decode_op(opc);
   wire logic [1:0]  nbytes   = op_bytes(cls);
   wire logic [2:0]  ncyc     = skip ? {1'b0, nbytes} : op_cycles(cls, opc);
   wire logic        last     = (step == ncyc - 3'd1);
   wire logic [14:0] seq_pc   = pc + {13'h0000, nbytes};
   wire logic [14:0] ret_pc   = hw_entry ? pc : seq_pc;
   wire logic [6:0]  pu_next  = seq_pc[`PC_MSB:`PU_LSB];
   wire logic        x_auto   = opc[3];
   wire logic        x_use_x  = x_auto ? opc[2] : opc[1];
   wire logic        x_xch    = x_auto ? opc[1] : opc[0];
   wire logic [7:0]  x_step   = opc[0] ? 8'hff : 8'h01;
   wire logic [7:0]  reg_addr = {`REG_PAGE, opc[3:0]};
   wire logic        reg_ptr  = (reg_addr == 8'hfc || reg_addr == 8'hfd || reg_addr == 8'hfe);
   wire logic [7:0]  reg_val  = (reg_addr == 8'hfc) ? x : ((reg_addr == 8'hfd) ? sp : b);
   wire logic [7:0]  reg_dec  = (reg_ptr ? reg_val : data_rdata) - 8'h01;

   // alu operand: immediate byte or memory byte
   wire logic [7:0]  alu_in   = (cls == alu_immediate) ? prog_data : data_rdata;
   wire alu_fn_t     alu_fn   = (cls == decimal_adjust) ? 4'h8 : {1'b0, opc[2:0]};
   logic [7:0]       alu_res;
   logic             alu_c;
   logic             alu_hc;
   logic             alu_cond;

   alu_unit u_alu
   (
      .acc_in         (acc),
      .operand        (alu_in),
      .carry_in       (carry),
      .half_carry_in  (half_carry),
      .fn             (alu_fn),
      .result         (alu_res),
      .carry_out      (alu_c),
      .half_carry_out (alu_hc),
      .cond_true      (alu_cond)
   );

   always_comb
   begin
      next_pc         = pc;
      next_prog_addr  = prog_addr;
      next_b          = b;
      next_x          = x;
      next_sp         = sp;
      next_acc        = acc;
      next_carry      = carry;
      next_half_carry = half_carry;
      next_gie        = global_irq_en;
      next_skip       = skip;
      next_hw_entry   = hw_entry;
      next_irq_ack    = 1'b0;
      next_step       = step + 3'd1;
      next_t1         = t1;
      next_t2         = t2;
      next_data_addr  = data_addr;
      next_data_wr    = 1'b0;
      next_data_wdata = data_wdata;
      tgt             = seq_pc;
      skip_set        = 1'b0;
      if (step == 3'd0)
         next_prog_addr = pc + 15'd1;
      if (step == 3'd1)
         next_prog_addr = pc + 15'd2;
      if (!skip)
      begin
         unique case (cls)
            no_op: ;
            software_irq_entry, absolute_segment_call, long_absolute_call:
            begin
               // low byte at the stack top, upper part one below
               if (step == ((cls == software_irq_entry) ? 3'd0 : nbytes - 2'd1))
               begin
                  next_data_addr  = sp;
                  next_data_wr    = 1'b1;
                  next_data_wdata = ret_pc[`PL_MSB:0];
               end
               if (step == ((cls == software_irq_entry) ? 3'd1 : {1'b0, nbytes}))
               begin
                  next_data_addr  = sp - 8'h01;
                  next_data_wr    = 1'b1;
                  next_data_wdata = {1'b0, ret_pc[`PC_MSB:`PU_LSB]};
               end
               if (step == 3'd1)
                  next_t1 = prog_data;
               if (step == 3'd2)
                  next_t2 = prog_data;
               if (step == ((cls == software_irq_entry) ? 3'd2 : 3'd4))
                  next_sp = sp - 8'h02;
               if (cls == software_irq_entry)
               begin
                  tgt = `SWI_VECTOR;
                  if (last)
                     next_gie = 1'b0;
               end
               else if (cls == absolute_segment_call)
                  tgt = {pc[`PC_MSB:`SEG_LSB], opc[3:0], t1};
               else
                  tgt = {t1[6:0], t2};
            end
            load_reg_imm:
               if (step == 3'd1)
               begin
                  if (opc[1:0] == 2'd1)
                     next_x = prog_data;
                  else if (opc[1:0] == 2'd2)
                     next_sp = prog_data;
                  else
                     next_b = prog_data;
               end
            short_relative_jump:
               tgt = pc + {9'h000, opc[5:0]} - `JP_BIAS;
            load_b_short:
               next_b = {4'h0, opc[3:0]};
            b_nibble_compare_skip:
               skip_set = (b[3:0] == opc[3:0]);
            absolute_segment_jump, long_absolute_jump:
            begin
               if (step == 3'd1)
                  next_t1 = prog_data;
               if (step == 3'd2)
                  next_t2 = prog_data;
               if (cls == absolute_segment_jump)
                  tgt = {pc[`PC_MSB:`SEG_LSB], opc[3:0], t1};
               else
                  tgt = {t1[6:0], t2};
            end
            decrement_skip_zero:
            begin
               if (step == 3'd0)
                  next_data_addr = reg_addr;
               if (step == 3'd1)
               begin
                  next_t1 = reg_dec;
                  if (reg_addr == 8'hfc)
                     next_x = reg_dec;
                  else if (reg_addr == 8'hfd)
                     next_sp = reg_dec;
                  else if (reg_addr == 8'hfe)
                     next_b = reg_dec;
                  else
                  begin
                     next_data_wr    = 1'b1;
                     next_data_wdata = reg_dec;
                  end
               end
               skip_set = (t1 == 8'h00);
            end
            alu_indirect, alu_immediate, alu_direct:
            begin
               if (cls == alu_direct && step == 3'd1)
                  next_data_addr = prog_data;
               if (last && opc[2:1] != 2'b11)
               begin
                  next_acc        = alu_res;
                  next_carry      = alu_c;
                  next_half_carry = alu_hc;
               end
               skip_set = (opc[2:1] == 2'b11) && !alu_cond;
            end
            load_acc_from_rom_table, jump_via_rom_table:
            begin
               if (step == 3'd0)
                  next_prog_addr = {pu_next, acc};
               if (step == 3'd1)
               begin
                  next_t1 = prog_data;
                  if (cls == load_acc_from_rom_table)
                     next_acc = prog_data;
               end
               if (cls == jump_via_rom_table)
                  tgt = {pu_next, t1};
            end
            vector_to_service:
            begin
               if (step == 3'd0)
                  next_prog_addr = irq_vec_addr;
               if (step == 3'd1)
               begin
                  next_t1        = prog_data;
                  next_prog_addr = irq_vec_addr + 15'd1;
               end
               if (step == 3'd2)
                  next_t2 = prog_data;
               tgt = {t1[6:0], t2};
            end
            subroutine_exit, exit_and_skip, interrupt_exit:
            begin
               if (step == 3'd0)
                  next_data_addr = sp + 8'h02;
               if (step == 3'd1)
               begin
                  next_t1        = data_rdata;
                  next_data_addr = sp + 8'h01;
               end
               if (step == 3'd2)
               begin
                  next_t2 = data_rdata;
                  next_sp = sp + 8'h02;
               end
               tgt      = {t2[6:0], t1};
               skip_set = (cls == exit_and_skip);
               if (last && cls == interrupt_exit)
                  next_gie = 1'b1;
            end
            push_acc:
            begin
               if (step == 3'd0)
               begin
                  next_data_addr  = sp;
                  next_data_wr    = 1'b1;
                  next_data_wdata = acc;
               end
               if (step == 3'd1)
                  next_sp = sp - 8'h01;
            end
            pop_acc:
            begin
               if (step == 3'd0)
               begin
                  next_sp        = sp + 8'h01;
                  next_data_addr = sp + 8'h01;
               end
               if (step == 3'd1)
                  next_acc = data_rdata;
            end
            decimal_adjust:
               next_acc = alu_res;
            mask_test_skip:
               skip_set = ((acc & prog_data) == 8'h00);
            mem_transfer:
            begin
               if (step == 3'd0 && x_use_x)
                  next_data_addr = x;
               if (step == (x_use_x ? 3'd1 : 3'd0))
               begin
                  next_acc        = data_rdata;
                  next_data_wr    = x_xch;
                  next_data_wdata = acc;
               end
               if (last && x_auto)
               begin
                  if (x_use_x)
                     next_x = x + x_step;
                  else
                     next_b = b + x_step;
               end
            end
         endcase
      end
      if (last)
      begin
         next_step      = 3'd0;
         next_pc        = tgt;
         next_prog_addr = tgt;
         next_data_addr = next_b;
         next_skip      = skip_set && !skip;
         next_hw_entry  = irq_req && next_gie && !next_skip;
         next_irq_ack   = next_hw_entry;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         pc            <= `PC_RESET;
         prog_addr     <= `PC_RESET;
         b             <= 8'h00;
         x             <= 8'h00;
         sp            <= `SP_RESET;
         acc           <= 8'h00;
         carry         <= 1'b0;
         half_carry    <= 1'b0;
         global_irq_en <= 1'b0;
         skip          <= 1'b0;
         hw_entry      <= 1'b0;
         irq_ack       <= 1'b0;
         step          <= 3'd0;
         op            <= 8'h00;
         t1            <= 8'h00;
         t2            <= 8'h00;
         data_addr     <= 8'h00;
         data_wr       <= 1'b0;
         data_wdata    <= 8'h00;
      end
      else
      begin
         pc            <= next_pc;
         prog_addr     <= next_prog_addr;
         b             <= next_b;
         x             <= next_x;
         sp            <= next_sp;
         acc           <= next_acc;
         carry         <= next_carry;
         half_carry    <= next_half_carry;
         global_irq_en <= next_gie;
         skip          <= next_skip;
         hw_entry      <= next_hw_entry;
         irq_ack       <= next_irq_ack;
         step          <= next_step;
         op            <= opc;
         t1            <= next_t1;
         t2            <= next_t2;
         data_addr     <= next_data_addr;
         data_wr       <= next_data_wr;
         data_wdata    <= next_data_wdata;
      end
   end

endmodule
